// [logic/rdtov_pkg.sv]
// Purpose: Shared constants of the residual definite-time overvoltage block
// Assumes: 125 MHz mclk, 32-bit classic Wishbone register port
// Notes: Register words are byte addresses, one aligned word each
package rdtov_pkg;

    // Clock and processing tick
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_DELAY = 8'h08;
    localparam logic [7:0] ADDR_NOMINAL = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

    // Control fields
    localparam int CTRL_OPER_BIT = 0;
    localparam int CTRL_PONLY_BIT = 1;
    localparam logic CTRL_OPER_RESET = 1'b1;
    localparam logic CTRL_PONLY_RESET = 1'b0;

    // Pickup level, percent of nominal
    localparam int LEVEL_W = 7;
    localparam logic [6:0] LEVEL_MIN = 7'h02;
    localparam logic [6:0] LEVEL_MAX = 7'h3C;
    localparam logic [6:0] LEVEL_RESET = 7'h1E;
    localparam logic [6:0] PCT_SCALE = 7'h64;

    // Definite delay, milliseconds
    localparam int DELAY_W = 16;
    localparam logic [15:0] DELAY_MAX = 16'hEA60;
    localparam logic [15:0] DELAY_RESET = 16'h0064;

    // Measurement and nominal scaling
    localparam int MEAS_W = 16;
    localparam int PROD_W = MEAS_W + LEVEL_W;
    localparam logic [15:0] NOMINAL_RESET = 16'h2710;

    // Status and interrupt fields
    localparam int STAT_PICKUP_BIT = 0;
    localparam int STAT_TRIP_BIT = 1;
    localparam int STAT_GPICK_BIT = 2;
    localparam int STAT_GTRIP_BIT = 3;
    localparam int STAT_BLOCK_BIT = 4;
    localparam int IRQ_W = 3;
    localparam int IRQ_PICK_RISE = 0;
    localparam int IRQ_TRIP_RISE = 1;
    localparam int IRQ_PICK_FALL = 2;

endpackage : rdtov_pkg

// [logic/rdtov_delay_timer.sv]
// Purpose: Definite-time delay counter in millisecond steps
// Assumes: run held high while picked up
// Notes: Prescaler restarts with run so every delay is exact
`timescale 1ns/100ps
module rdtov_delay_timer
    import rdtov_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
    parameter int DW = DELAY_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Control
    input wire logic run,
    input wire logic [DW-1:0] delay_ms,
    // Result
    output logic [DW-1:0] elapsed_ms,
    output logic done
);

    localparam int PW = $clog2(TICK_CYCLES_P + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES_P - 1);

    logic [PW-1:0] prescale;

    // Prescaler counts mclk cycles of one millisecond
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prescale <= '0;
        end else if (!run || prescale == PRE_LAST) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    // Elapsed time saturates at the setting so a long hold cannot wrap
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            elapsed_ms <= '0;
        end else if (!run) begin
            elapsed_ms <= '0;
        end else if (prescale == PRE_LAST && elapsed_ms < delay_ms) begin
            elapsed_ms <= elapsed_ms + 1'b1;
        end
    end

    assign done = run && (elapsed_ms >= delay_ms);

endmodule : rdtov_delay_timer

// [logic/rdtov_top.sv]
// Purpose: Residual definite-time overvoltage decision block with Wishbone registers
// Assumes: Measurement and block input come from logic on mclk
// Notes: Outputs lag the measurement by two clocks and the block input by one; delay resolution is 1 ms
`timescale 1ns/100ps
module rdtov_top
    import rdtov_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Measurement and blocking
    input wire logic [MEAS_W-1:0] residual_fundamental_rms,
    input wire logic block_input,
    // Decisions
    output logic general_pickup_out,
    output logic general_trip_out,
    output logic irq
);

    // Settings
    logic function_operation_select;
    logic pickup_only_select;
    logic [LEVEL_W-1:0] residual_pickup_level;
    logic [DELAY_W-1:0] definite_delay_setting;
    logic [MEAS_W-1:0] nominal_level;

    // State
    logic pickup_flag;
    logic delayed_trip_flag;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [DELAY_W-1:0] elapsed_ms;
    logic delay_done;

    // Bus decode
    logic bus_req;
    logic wr_en;
    logic [31:0] next_nominal;
    logic [31:0] next_rd;

    // Decision terms
    logic [PROD_W-1:0] meas_scaled;
    logic [PROD_W-1:0] level_scaled;
    logic above_level;
    logic next_pickup;
    logic next_trip;
    logic next_gpick;
    logic next_gtrip;
    logic [IRQ_W-1:0] irq_event;

    // Byte-lane merge of a write into the current register value
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_lanes

    // Out-of-range level and delay settings are clamped rather than refused, so a setting is always legal
    function automatic logic [LEVEL_W-1:0] clamp_level(input logic [31:0] v);
        logic [LEVEL_W-1:0] r;
        if (v < 32'(LEVEL_MIN)) begin
            r = LEVEL_MIN;
        end else if (v > 32'(LEVEL_MAX)) begin
            r = LEVEL_MAX;
        end else begin
            r = v[LEVEL_W-1:0];
        end
        return r;
    endfunction : clamp_level

    function automatic logic [DELAY_W-1:0] clamp_delay(input logic [31:0] v);
        logic [DELAY_W-1:0] r;
        if (v > 32'(DELAY_MAX)) begin
            r = DELAY_MAX;
        end else begin
            r = v[DELAY_W-1:0];
        end
        return r;
    endfunction : clamp_delay

    // ---- Wishbone slave: one wait state, ack for one cycle ----
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en = bus_req && wb_we_i;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_comb begin
        next_rd = 32'h0000_0000;
        if (wb_adr_i == ADDR_CTRL) begin
            next_rd[CTRL_OPER_BIT] = function_operation_select;
            next_rd[CTRL_PONLY_BIT] = pickup_only_select;
        end else if (wb_adr_i == ADDR_LEVEL) begin
            next_rd[LEVEL_W-1:0] = residual_pickup_level;
        end else if (wb_adr_i == ADDR_DELAY) begin
            next_rd[DELAY_W-1:0] = definite_delay_setting;
        end else if (wb_adr_i == ADDR_NOMINAL) begin
            next_rd[MEAS_W-1:0] = nominal_level;
        end else if (wb_adr_i == ADDR_STATUS) begin
            next_rd[STAT_PICKUP_BIT] = pickup_flag;
            next_rd[STAT_TRIP_BIT] = delayed_trip_flag;
            next_rd[STAT_GPICK_BIT] = general_pickup_out;
            next_rd[STAT_GTRIP_BIT] = general_trip_out;
            next_rd[STAT_BLOCK_BIT] = block_input;
        end else if (wb_adr_i == ADDR_IRQ_STAT) begin
            next_rd[IRQ_W-1:0] = irq_status;
        end else if (wb_adr_i == ADDR_IRQ_MASK) begin
            next_rd[IRQ_W-1:0] = irq_mask;
        end
    end

    // Read data registered with the ack; unmapped addresses read zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= next_rd;
        end
    end

    // ---- Settings registers ----
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            function_operation_select <= CTRL_OPER_RESET;
            pickup_only_select <= CTRL_PONLY_RESET;
        end else if (wr_en && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
            function_operation_select <= wb_dat_i[CTRL_OPER_BIT];
            pickup_only_select <= wb_dat_i[CTRL_PONLY_BIT];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            residual_pickup_level <= LEVEL_RESET;
        end else if (wr_en && wb_adr_i == ADDR_LEVEL) begin
            residual_pickup_level <= clamp_level(merge_lanes(32'(residual_pickup_level), wb_dat_i, wb_sel_i));
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            definite_delay_setting <= DELAY_RESET;
        end else if (wr_en && wb_adr_i == ADDR_DELAY) begin
            definite_delay_setting <= clamp_delay(merge_lanes(32'(definite_delay_setting), wb_dat_i, wb_sel_i));
        end
    end

    // A nominal too wide for the measurement path is ignored rather than truncated
    assign next_nominal = merge_lanes(32'(nominal_level), wb_dat_i, wb_sel_i);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nominal_level <= NOMINAL_RESET;
        end else if (wr_en && wb_adr_i == ADDR_NOMINAL && next_nominal[31:MEAS_W] == '0) begin
            nominal_level <= next_nominal[MEAS_W-1:0];
        end
    end

    // ---- Start decision ----
    // Cross-multiplied compare avoids a divider: rms * 100 > level * nominal
    assign meas_scaled = PROD_W'(residual_fundamental_rms) * PROD_W'(PCT_SCALE);
    assign level_scaled = PROD_W'(residual_pickup_level) * PROD_W'(nominal_level);
    assign above_level = meas_scaled > level_scaled;
    assign next_pickup = function_operation_select && above_level;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pickup_flag <= 1'b0;
        end else begin
            pickup_flag <= next_pickup;
        end
    end

    // ---- Definite delay: fixed by the setting alone ----
    rdtov_delay_timer #(
        .TICK_CYCLES_P(TICK_CYCLES_P),
        .DW(DELAY_W)
    ) u_delay (
        .mclk(mclk),
        .nrst(nrst),
        .run(pickup_flag),
        .delay_ms(definite_delay_setting),
        .elapsed_ms(elapsed_ms),
        .done(delay_done)
    );

    // Trip needs the level still exceeded in the same cycle the delay completes
    assign next_trip = next_pickup && delay_done;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            delayed_trip_flag <= 1'b0;
        end else begin
            delayed_trip_flag <= next_trip;
        end
    end

    // ---- Decision logic ----
    assign next_gpick = pickup_flag && function_operation_select && !block_input;
    assign next_gtrip = delayed_trip_flag && function_operation_select && !block_input
                        && !pickup_only_select;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            general_pickup_out <= 1'b0;
            general_trip_out <= 1'b0;
        end else begin
            general_pickup_out <= next_gpick;
            general_trip_out <= next_gtrip;
        end
    end

    // ---- Interrupts: sticky, write one to clear, set beats clear ----
    assign irq_event[IRQ_PICK_RISE] = next_gpick && !general_pickup_out;
    assign irq_event[IRQ_TRIP_RISE] = next_gtrip && !general_trip_out;
    assign irq_event[IRQ_PICK_FALL] = !next_gpick && general_pickup_out;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= '0;
        end else if (wr_en && wb_adr_i == ADDR_IRQ_STAT && wb_sel_i[0]) begin
            irq_status <= (irq_status & ~wb_dat_i[IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_mask <= '0;
        end else if (wr_en && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask <= wb_dat_i[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ---- Checks ----
    AST_PICKUP_CAUSE: assert property (@(posedge mclk) disable iff (!nrst)
        function_operation_select && above_level |=> pickup_flag)
        else $error("pickup flag did not follow an exceeded level");

    AST_DROP_ALL: assert property (@(posedge mclk) disable iff (!nrst)
        !above_level |=> !pickup_flag && !delayed_trip_flag ##1 elapsed_ms == '0)
        else $error("drop-out did not clear pickup, trip and delay");

    AST_LEVEL_RANGE: assert property (@(posedge mclk) disable iff (!nrst)
        residual_pickup_level >= LEVEL_MIN && residual_pickup_level <= LEVEL_MAX)
        else $error("start level outside its range");

    AST_DELAY_RANGE: assert property (@(posedge mclk) disable iff (!nrst)
        definite_delay_setting <= DELAY_MAX)
        else $error("delay setting above its maximum");

    AST_TRIP_AFTER_DELAY: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(delayed_trip_flag) |-> $past(pickup_flag) && $past(elapsed_ms) >= $past(definite_delay_setting))
        else $error("trip rose before the delay elapsed");

    AST_TRIP_FIXED_TIME: assert property (@(posedge mclk) disable iff (!nrst)
        pickup_flag && above_level && function_operation_select && delay_done |=> delayed_trip_flag)
        else $error("trip late although the delay had elapsed");

    AST_OFF_QUIET: assert property (@(posedge mclk) disable iff (!nrst)
        !function_operation_select |=> !general_pickup_out && !general_trip_out)
        else $error("output asserted while operation is off");

    AST_PICKUP_ONLY: assert property (@(posedge mclk) disable iff (!nrst)
        pickup_only_select |=> !general_trip_out)
        else $error("general trip asserted in pickup-only mode");

    AST_BLOCKED: assert property (@(posedge mclk) disable iff (!nrst)
        block_input |=> !general_pickup_out && !general_trip_out)
        else $error("output asserted while blocked");

    AST_GEN_PICKUP: assert property (@(posedge mclk) disable iff (!nrst)
        pickup_flag && function_operation_select && !block_input |=> general_pickup_out)
        else $error("general pickup missing");

    AST_GEN_TRIP: assert property (@(posedge mclk) disable iff (!nrst)
        delayed_trip_flag && function_operation_select && !block_input && !pickup_only_select |=> general_trip_out)
        else $error("general trip missing");

    AST_PICKUP_NEEDS_LEVEL: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(pickup_flag) |-> $past(function_operation_select) && $past(above_level))
        else $error("pickup rose without an exceeded level");

    AST_TRIP_NEEDS_PICKUP: assert property (@(posedge mclk) disable iff (!nrst)
        delayed_trip_flag |-> pickup_flag)
        else $error("trip flag without pickup");

    AST_TIMER_RESTART: assert property (@(posedge mclk) disable iff (!nrst)
        !pickup_flag |=> elapsed_ms == '0)
        else $error("delay count kept after drop-out");

    AST_OFF_NO_PICKUP: assert property (@(posedge mclk) disable iff (!nrst)
        !function_operation_select |=> !pickup_flag)
        else $error("pickup flag raised while operation is off");

    AST_PONLY_PICKUP_KEPT: assert property (@(posedge mclk) disable iff (!nrst)
        pickup_flag && function_operation_select && !block_input && pickup_only_select |=> general_pickup_out)
        else $error("general pickup lost in pickup-only mode");

    AST_GPICK_NEEDS_PICKUP: assert property (@(posedge mclk) disable iff (!nrst)
        general_pickup_out |-> $past(pickup_flag) && !$past(block_input) && $past(function_operation_select))
        else $error("general pickup without its causes");

    AST_GTRIP_NEEDS_TRIP: assert property (@(posedge mclk) disable iff (!nrst)
        general_trip_out |-> $past(delayed_trip_flag) && !$past(pickup_only_select))
        else $error("general trip without its causes");

endmodule : rdtov_top

// [tb/rdtov_meas_model.sv]
// Purpose: Stand-in for the measurement stage that feeds the residual RMS value
// Assumes: One fresh value per mclk edge, no handshake
// Notes: Output is zero in reset, like a filter that has not settled
`timescale 1ns/100ps
module rdtov_meas_model
    import rdtov_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Requested magnitude
    input wire logic [MEAS_W-1:0] target,
    // Measured value
    output logic [MEAS_W-1:0] rms
);
    // Registered so the block never sees a change inside an edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rms <= '0;
        end else begin
            rms <= target;
        end
    end
endmodule : rdtov_meas_model

// [tb/testbench.sv]
// Purpose: Register and decision checks of the residual overvoltage block
// Assumes: Tick shortened to 10 clocks, nominal left at reset value
// Notes: Level 30 percent of 10000 puts the pickup edge between 3000 and 3001
`timescale 1ns/100ps
module testbench;
    import rdtov_pkg::*;
    localparam int unsigned TK = 10;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic wb_ack_o, general_pickup_out, general_trip_out, irq;
    logic [MEAS_W-1:0] target = '0, rms;
    logic block_input = 1'b0;
    int bad_count = 0, comparisons = 0, n, tt[2];
    logic [15:0] mags[2] = '{16'h0BB9, 16'h2328};

    always #4 mclk = ~mclk;

    rdtov_meas_model rdtov_meas_model_inst (.mclk(mclk), .nrst(nrst), .target(target), .rms(rms));
    rdtov_top #(.TICK_CYCLES_P(TK)) rdtov_top_inst (.mclk(mclk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .residual_fundamental_rms(rms), .block_input(block_input),
        .general_pickup_out(general_pickup_out), .general_trip_out(general_trip_out), .irq(irq));

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Request held until ack is sampled high at a rising edge; read data taken at that same edge
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        bit got;
        got = 1'b0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        for (int i = 0; i < 50 && !got; i++) begin
            @(posedge mclk);
            got = (wb_ack_o === 1'b1);
        end
        if (!got) begin
            check("bus ack", 32'h0, 32'h1);
            wrap_up();
        end else begin
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask : xfer

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        xfer(1'b0, adr, 32'h0);
        check(what, q, exp);
    endtask : rd_chk

    task automatic drive(input logic [15:0] v, input logic blk);
        @(posedge mclk);
        target <= v;
        block_input <= blk;
    endtask : drive

    task automatic wait_out(input bit trip, input logic val, output int cnt);
        for (cnt = 0; cnt < 400; cnt++) begin
            @(posedge mclk);
            #1;
            if ((trip ? general_trip_out : general_pickup_out) === val) return;
        end
        check(trip ? "trip wait" : "pickup wait", 32'h0, 32'h1);
        wrap_up();
    endtask : wait_out

    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd_chk("ctrl reset", ADDR_CTRL, 32'h1);
        rd_chk("level reset", ADDR_LEVEL, 32'h1E);
        rd_chk("delay reset", ADDR_DELAY, 32'h64);
        rd_chk("mask reset", ADDR_IRQ_MASK, 32'h0);
        rd_chk("nominal reset", ADDR_NOMINAL, 32'h2710);
        xfer(1'b1, ADDR_NOMINAL, 32'h0001_0000);
        rd_chk("nominal wide write", ADDR_NOMINAL, 32'h2710);
        rd_chk("unmapped", 8'h1C, 32'h0);
        xfer(1'b1, ADDR_LEVEL, 32'h1);
        rd_chk("level low clamp", ADDR_LEVEL, 32'h2);
        xfer(1'b1, ADDR_LEVEL, 32'h7F);
        rd_chk("level high clamp", ADDR_LEVEL, 32'h3C);
        xfer(1'b1, ADDR_DELAY, 32'hFFFF);
        rd_chk("delay clamp", ADDR_DELAY, 32'hEA60);
        xfer(1'b1, ADDR_LEVEL, 32'h1E);
        xfer(1'b1, ADDR_DELAY, 32'h2);
        drive(16'h0BB8, 1'b0);
        repeat (6) @(posedge mclk);
        #1;
        check("equal level no pickup", 32'(general_pickup_out), 32'h0);
        // Just above and far above the level must trip after the same time
        for (int k = 0; k < 2; k++) begin
            drive(mags[k], 1'b0);
            wait_out(1'b0, 1'b1, n);
            check("pickup latency", 32'(n <= 3), 32'h1);
            wait_out(1'b1, 1'b1, tt[k]);
            check("trip delay", 32'(tt[k] >= 2 * TK - 3 && tt[k] <= 2 * TK + 2), 32'h1);
            drive(16'h0BB8, 1'b0);
            wait_out(1'b0, 1'b0, n);
            check("drop latency", 32'(n <= 3 && general_trip_out === 1'b0), 32'h1);
        end
        check("trip time", 32'(tt[0]), 32'(tt[1]));
        xfer(1'b1, ADDR_DELAY, 32'h0);
        drive(16'h1388, 1'b0);
        wait_out(1'b0, 1'b1, n);
        wait_out(1'b1, 1'b1, n);
        check("zero delay trip", 32'(n <= 2), 32'h1);
        drive(16'h1388, 1'b1);
        wait_out(1'b0, 1'b0, n);
        check("block", 32'({general_trip_out, 1'b0} | 2'(n > 2)), 32'h0);
        rd_chk("status blocked", ADDR_STATUS, 32'h13);
        drive(16'h1388, 1'b0);
        wait_out(1'b0, 1'b1, n);
        xfer(1'b1, ADDR_CTRL, 32'h0);
        wait_out(1'b0, 1'b0, n);
        check("off trip", 32'(general_trip_out), 32'h0);
        xfer(1'b1, ADDR_CTRL, 32'h3);
        wait_out(1'b0, 1'b1, n);
        repeat (30) @(posedge mclk);
        #1;
        check("pickup only trip", 32'(general_trip_out), 32'h0);
        xfer(1'b1, ADDR_CTRL, 32'h1);
        drive(16'h0000, 1'b0);
        wait_out(1'b0, 1'b0, n);
        xfer(1'b1, ADDR_IRQ_STAT, 32'h7);
        xfer(1'b1, ADDR_IRQ_MASK, 32'h1);
        for (int k = 0; k < 2; k++) begin
            drive(16'h1388, 1'b0);
            wait_out(1'b1, 1'b1, n);
            repeat (2) @(posedge mclk);
            #1;
            check("irq raised", 32'(irq), 32'(k == 0));
            rd_chk("irq status", ADDR_IRQ_STAT, 32'h3);
            drive(16'h0000, 1'b0);
            wait_out(1'b0, 1'b0, n);
            rd_chk("irq fall", ADDR_IRQ_STAT, 32'h7);
            xfer(1'b1, ADDR_IRQ_STAT, 32'h7);
            check("irq cleared", 32'(irq), 32'h0);
            xfer(1'b1, ADDR_IRQ_MASK, 32'h0);
        end
        wrap_up();
    end
endmodule : testbench
